// File: design/spc_cfg.svh
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define SPC_ADDR_FLAGS 16'h1920
`define SPC_ADDR_WAKE 16'h1930
`define SPC_ADDR_RAM 16'h1C28
`define SPC_ADDR_IRQ_STAT 16'h1940
`define SPC_ADDR_IRQ_CLR 16'h1944
`define SPC_ADDR_IRQ_EN 16'h1948
`define SPC_ADDR_PWR_CFG 16'h194C
// ----------------------------------------
// field positions
// ----------------------------------------
`define SPC_BIT_DRIVE 4
`define SPC_BIT_DIR 3
`define SPC_BIT_CLKOUT 0
`define SPC_BIT_ALARM 15
`define SPC_LSB_PERIODIC 0
`define SPC_MSB_PERIODIC 5
`define SPC_LSB_RAM 0
`define SPC_MSB_RAM 3
`define SPC_LSB_TARGET 0
`define SPC_MSB_TARGET 1
`define SPC_LSB_STATE 4
`define SPC_MSB_STATE 5
`define SPC_IRQ_W 4
`define SPC_IRQ_RTC 0
`define SPC_IRQ_PIN 1
`define SPC_IRQ_INT0 2
`define SPC_IRQ_INT1 3
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define SPC_RST_RAM 4'hF
`define SPC_RST_IRQ 4'h0
`define SPC_RST_SYNC_N 3'h7
`define SPC_TGT_ACTIVE 2'h0
`define SPC_TGT_LIGHT 2'h1
`define SPC_TGT_DEEP 2'h2
`define SPC_SYNC_W 3
`endif

// File: design/spc_pkg.sv
package spc_pkg;
  `include "spc_cfg.svh"
  // power configurations, gray along active-light-deep
  typedef enum logic [1:0] {
    SPC_ACTIVE = 2'h0,
    SPC_LIGHT = 2'h1,
    SPC_DEEP = 2'h3
  } spc_pwr_e;
  // rtc event pulses, one bit per flag
  typedef struct packed {
    logic alarm;
    logic external_evt;
    logic day;
    logic hour;
    logic minute;
    logic second;
    logic millisecond;
  } spc_rtc_evt_s;
  // apb request from the master
  typedef struct packed {
    logic [15:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } spc_apb_req_s;
  // apb answer
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } spc_apb_rsp_s;
  // clock domain enables
  typedef struct packed {
    logic cpu;
    logic clkgen;
    logic periph;
    logic rtc;
  } spc_clk_en_s;
  // ram sleep controls, laid out as the register
  typedef struct packed {
    logic single_ram_supply_control;
    logic single_ram_ground_control;
    logic dual_ram_supply_control;
    logic dual_ram_ground_control;
  } spc_ram_ctrl_s;
  // whole block state
  typedef struct packed {
    logic [31:0] prdata;
    logic pslverr;
    logic wake_pin_drive_level;
    logic wake_pin_direction;
    logic rtc_clock_output_enable;
    spc_rtc_evt_s flags;
    spc_ram_ctrl_s ram;
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    logic [1:0] target;
    spc_pwr_e pwr;
    spc_clk_en_s clk_en;
    logic [2:0] sync_pin;
    logic [2:0] sync_int0_n;
    logic [2:0] sync_int1_n;
  } spc_state_s;
endpackage

// File: design/spc_top.sv
`timescale 1ns/1ps
// What this block does
// - drive level bit 4: zero pulls wake pin low, one releases it
// - direction bit 3: zero makes wake pin input, one output
// - wake input is active high; output is open-drain, needs pull-up
// - alarm flag bit 15 sets on alarm event, clears on write one
// - external flag bit 5 sets on external event, write one clears
// - day, hour, minute, second, millisecond flags bits 4..0, W1C
// - both sleep bits one is active, supply one ground zero retains
// - dual ram mode is independent of single ram mode
// - retention puts ram in low power, contents kept
// - single ram controls at bits 3,2; dual ram at bits 1,0
// - deep idle: only rtc clock runs; pin, rtc, int0/1, reset wake
// - light idle: clock generator on too; peripheral irq also wakes
// - active: all clocks on; same wake and reset sources remain
module spc_top (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire spc_pkg::spc_apb_req_s apb_in,
  output spc_pkg::spc_apb_rsp_s apb_out,
  input wire spc_pkg::spc_rtc_evt_s rtc_evt_in,
  input wire logic wake_pin_in,
  output logic wake_pin_out,
  output logic wake_pin_oe_n_out,
  input wire logic external_interrupt_zero_n_in,
  input wire logic external_interrupt_one_n_in,
  input wire logic periph_irq_in,
  input wire logic idle_exec_in,
  output logic rtc_clock_output_enable_out,
  output spc_pkg::spc_ram_ctrl_s ram_ctrl_out,
  output logic single_ram_retention_out,
  output logic dual_ram_retention_out,
  output spc_pkg::spc_clk_en_s clk_en_out,
  output logic wake_out,
  output logic irq_out
);
  import spc_pkg::*;

  spc_state_s state_reg;
  spc_state_s state_next;

  // ----------------------------------------
  // bus phase decode
  // ----------------------------------------
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic addr_mapped;

  // setup latches read data, access commits
  assign setup_phase = apb_in.psel & ~apb_in.penable;
  assign access_phase = apb_in.psel & apb_in.penable;
  assign wr_access = access_phase & apb_in.pwrite;

  // known register addresses
  always_comb begin
    case (apb_in.paddr)
      `SPC_ADDR_FLAGS,
      `SPC_ADDR_WAKE,
      `SPC_ADDR_RAM,
      `SPC_ADDR_IRQ_STAT,
      `SPC_ADDR_IRQ_CLR,
      `SPC_ADDR_IRQ_EN,
      `SPC_ADDR_PWR_CFG: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // read views of the registers
  // ----------------------------------------
  logic [15:0] flags_word;
  logic [15:0] wake_word;
  logic [15:0] ram_word;
  logic [15:0] pwr_word;

  // unused positions stay zero
  always_comb begin
    flags_word = 16'h0000;
    flags_word[`SPC_BIT_ALARM] = state_reg.flags.alarm;
    flags_word[`SPC_MSB_PERIODIC:`SPC_LSB_PERIODIC] =
      {state_reg.flags.external_evt, state_reg.flags.day,
       state_reg.flags.hour, state_reg.flags.minute,
       state_reg.flags.second, state_reg.flags.millisecond};
    wake_word = 16'h0000;
    wake_word[`SPC_BIT_DRIVE] = state_reg.wake_pin_drive_level;
    wake_word[`SPC_BIT_DIR] = state_reg.wake_pin_direction;
    wake_word[`SPC_BIT_CLKOUT] = state_reg.rtc_clock_output_enable;
    ram_word = 16'h0000;
    ram_word[`SPC_MSB_RAM:`SPC_LSB_RAM] = state_reg.ram;
    pwr_word = 16'h0000;
    pwr_word[`SPC_MSB_TARGET:`SPC_LSB_TARGET] = state_reg.target;
    pwr_word[`SPC_MSB_STATE:`SPC_LSB_STATE] = state_reg.pwr;
  end

  // ----------------------------------------
  // read data select
  // ----------------------------------------
  logic [31:0] rd_data;

  // word for the setup capture; unmapped and write-only read zero
  always_comb begin
    case (apb_in.paddr)
      `SPC_ADDR_FLAGS: rd_data = {16'h0000, flags_word};
      `SPC_ADDR_WAKE: rd_data = {16'h0000, wake_word};
      `SPC_ADDR_RAM: rd_data = {16'h0000, ram_word};
      `SPC_ADDR_IRQ_STAT: rd_data = {28'h0000000, state_reg.irq_status};
      `SPC_ADDR_IRQ_EN: rd_data = {28'h0000000, state_reg.irq_enable};
      `SPC_ADDR_PWR_CFG: rd_data = {16'h0000, pwr_word};
      default: rd_data = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // write strobes and clear masks
  // ----------------------------------------
  logic wr_flags;
  logic wr_wake;
  logic wr_ram;
  logic wr_irq_clr;
  logic wr_irq_en;
  logic wr_pwr;
  spc_rtc_evt_s flag_clr;
  logic [3:0] irq_clr;

  // one strobe per writable register
  assign wr_flags = wr_access & (apb_in.paddr == `SPC_ADDR_FLAGS);
  assign wr_wake = wr_access & (apb_in.paddr == `SPC_ADDR_WAKE);
  assign wr_ram = wr_access & (apb_in.paddr == `SPC_ADDR_RAM);
  assign wr_irq_clr = wr_access & (apb_in.paddr == `SPC_ADDR_IRQ_CLR);
  assign wr_irq_en = wr_access & (apb_in.paddr == `SPC_ADDR_IRQ_EN);
  assign wr_pwr = wr_access & (apb_in.paddr == `SPC_ADDR_PWR_CFG);

  // write one to clear, only on flag positions
  always_comb begin
    flag_clr = '0;
    if (wr_flags) begin
      flag_clr.alarm = apb_in.pwdata[`SPC_BIT_ALARM];
      flag_clr = {apb_in.pwdata[`SPC_BIT_ALARM],
                  apb_in.pwdata[`SPC_MSB_PERIODIC:`SPC_LSB_PERIODIC]};
    end
  end

  // status clear mask
  assign irq_clr = wr_irq_clr ? apb_in.pwdata[`SPC_IRQ_W-1:0] : `SPC_RST_IRQ;

  // ----------------------------------------
  // pin and interrupt events
  // ----------------------------------------
  logic pin_level;
  logic int0_level;
  logic int1_level;
  logic [3:0] irq_set;
  logic rtc_any;
  logic wake_light;
  logic wake_deep;

  // second and third stages only
  assign pin_level = state_reg.sync_pin[1];
  assign int0_level = ~state_reg.sync_int0_n[1];
  assign int1_level = ~state_reg.sync_int1_n[1];
  assign rtc_any = |rtc_evt_in;

  // new events for the status register
  always_comb begin
    irq_set = `SPC_RST_IRQ;
    irq_set[`SPC_IRQ_RTC] = rtc_any;
    // pin is a wake source only as an input, active high
    irq_set[`SPC_IRQ_PIN] = ~state_reg.wake_pin_direction & pin_level
                            & ~state_reg.sync_pin[2];
    irq_set[`SPC_IRQ_INT0] = int0_level & state_reg.sync_int0_n[2];
    irq_set[`SPC_IRQ_INT1] = int1_level & state_reg.sync_int1_n[2];
  end

  // enabled status bits form the interrupt; deep wake also takes the input pin level unmasked
  assign wake_deep = |(state_reg.irq_status & state_reg.irq_enable)
                     | (~state_reg.wake_pin_direction & pin_level);
  assign wake_light = wake_deep | periph_irq_in;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    // synchronisers: first stage read only by second
    state_next.sync_pin = {state_reg.sync_pin[1:0], wake_pin_in};
    state_next.sync_int0_n = {state_reg.sync_int0_n[1:0],
                              external_interrupt_zero_n_in};
    state_next.sync_int1_n = {state_reg.sync_int1_n[1:0],
                              external_interrupt_one_n_in};
    // read data captured in setup, error flagged in setup
    if (setup_phase) begin
      state_next.pslverr = ~addr_mapped;
      state_next.prdata = rd_data;
    end
    // sticky flags, a new event wins over a clear
    state_next.flags = (state_reg.flags & ~flag_clr) | rtc_evt_in;
    state_next.irq_status = (state_reg.irq_status & ~irq_clr) | irq_set;
    // wake pin control and clock-out enable
    if (wr_wake) begin
      state_next.wake_pin_drive_level = apb_in.pwdata[`SPC_BIT_DRIVE];
      state_next.wake_pin_direction = apb_in.pwdata[`SPC_BIT_DIR];
      state_next.rtc_clock_output_enable = apb_in.pwdata[`SPC_BIT_CLKOUT];
    end
    // both ram pairs written together, each steers its own ram
    if (wr_ram) begin
      state_next.ram = apb_in.pwdata[`SPC_MSB_RAM:`SPC_LSB_RAM];
    end
    // enable bits double as the wake mask
    if (wr_irq_en) begin
      state_next.irq_enable = apb_in.pwdata[`SPC_IRQ_W-1:0];
    end
    // target only takes effect at the next idle instruction
    if (wr_pwr) begin
      state_next.target = apb_in.pwdata[`SPC_MSB_TARGET:`SPC_LSB_TARGET];
    end
    // power configuration sequencer
    case (state_reg.pwr)
      SPC_ACTIVE: begin
        // idle instruction applies the prepared target
        // targets zero and three leave the block active
        if (idle_exec_in & ~wake_light) begin
          if (state_reg.target == `SPC_TGT_LIGHT) begin
            state_next.pwr = SPC_LIGHT;
          end else if (state_reg.target == `SPC_TGT_DEEP) begin
            state_next.pwr = SPC_DEEP;
          end
        end
      end
      SPC_LIGHT: begin
        if (wake_light) begin
          state_next.pwr = SPC_ACTIVE;
        end
      end
      SPC_DEEP: begin
        if (wake_deep) begin
          state_next.pwr = SPC_ACTIVE;
        end
      end
      default: state_next.pwr = SPC_ACTIVE;
    endcase
    // clock domains follow the next configuration
    case (state_next.pwr)
      SPC_LIGHT: state_next.clk_en = '{cpu: 1'b0, clkgen: 1'b1,
                                       periph: 1'b0, rtc: 1'b1};
      SPC_DEEP: state_next.clk_en = '{cpu: 1'b0, clkgen: 1'b0,
                                      periph: 1'b0, rtc: 1'b1};
      default: state_next.clk_en = '{cpu: 1'b1, clkgen: 1'b1,
                                     periph: 1'b1, rtc: 1'b1};
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
      state_reg.ram <= `SPC_RST_RAM;
      state_reg.pwr <= SPC_ACTIVE;
      state_reg.clk_en <= '{cpu: 1'b1, clkgen: 1'b1,
                            periph: 1'b1, rtc: 1'b1};
      // active-low inputs rest high, so no false edge after reset
      state_reg.sync_int0_n <= `SPC_RST_SYNC_N;
      state_reg.sync_int1_n <= `SPC_RST_SYNC_N;
      state_reg.target <= `SPC_TGT_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // zero-wait answer in the access phase
  assign apb_out.pready = access_phase;
  assign apb_out.prdata = state_reg.prdata;
  assign apb_out.pslverr = state_reg.pslverr & access_phase;

  // open-drain: only ever pulls low, oe low while driving
  assign wake_pin_out = 1'b0;
  assign wake_pin_oe_n_out = ~(state_reg.wake_pin_direction
                               & ~state_reg.wake_pin_drive_level);

  assign rtc_clock_output_enable_out = state_reg.rtc_clock_output_enable;
  assign ram_ctrl_out = state_reg.ram;

  // supply on, ground off is retention; each ram on its own pair
  assign single_ram_retention_out = state_reg.ram.single_ram_supply_control
    & ~state_reg.ram.single_ram_ground_control;
  assign dual_ram_retention_out = state_reg.ram.dual_ram_supply_control
    & ~state_reg.ram.dual_ram_ground_control;

  assign clk_en_out = state_reg.clk_en;
  // one-cycle pulse in the cycle the sequencer leaves idle
  assign wake_out = (state_reg.pwr != SPC_ACTIVE) & (state_next.pwr == SPC_ACTIVE);
  // level interrupt while an enabled sticky bit is set
  assign irq_out = |(state_reg.irq_status & state_reg.irq_enable);
endmodule

// File: tb/spc_board_model.sv
`timescale 1ns/1ps
module spc_board_model (
  input wire logic data_in,
  input wire logic oe_n_in,
  input wire logic board_en_in,
  input wire logic board_lvl_in,
  output logic level_out
);
  // open-drain line, board source or pull-up when nobody drives
  assign level_out = !oe_n_in ? data_in : (board_en_in ? board_lvl_in : 1'b1);
endmodule

// File: tb/spc_properties.sv
`timescale 1ns/1ps
module spc_checker (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire spc_pkg::spc_apb_req_s apb_in,
  input wire spc_pkg::spc_apb_rsp_s apb_out,
  input wire logic wake_pin_out,
  input wire logic wake_pin_oe_n_out,
  input wire spc_pkg::spc_ram_ctrl_s ram_ctrl_out,
  input wire logic single_ram_retention_out,
  input wire logic dual_ram_retention_out,
  input wire spc_pkg::spc_clk_en_s clk_en_out,
  input wire logic wake_out,
  input wire logic irq_out
);
  import spc_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic wr_acc;
  logic rd_acc;
  // committing write and read access phases
  assign wr_acc = apb_in.psel && apb_in.penable && apb_in.pwrite;
  assign rd_acc = apb_in.psel && apb_in.penable && !apb_in.pwrite;
  a_pin_data_low: assert property (wake_pin_out == 1'b0)
    else $error("wake pin data not low");
  a_pin_pulls_low: assert property (wr_acc && apb_in.paddr == 16'h1930 &&
    apb_in.pwdata[4:3] == 2'h1 |=> !wake_pin_oe_n_out) else $error("wake pin not pulled");
  a_pin_released: assert property (wr_acc && apb_in.paddr == 16'h1930 &&
    apb_in.pwdata[4:3] != 2'h1 |=> wake_pin_oe_n_out) else $error("wake pin not released");
  a_ram_write_takes: assert property (wr_acc && apb_in.paddr == 16'h1C28
    |=> ram_ctrl_out == $past(apb_in.pwdata[3:0])) else $error("ram control not written");
  a_single_ret_decode: assert property (single_ram_retention_out ==
    (ram_ctrl_out[3] && !ram_ctrl_out[2])) else $error("single ram mode wrong");
  a_dual_ret_decode: assert property (dual_ram_retention_out ==
    (ram_ctrl_out[1] && !ram_ctrl_out[0])) else $error("dual ram mode wrong");
  a_wake_reserved_zero: assert property (rd_acc && apb_in.paddr == 16'h1930 |->
    apb_out.prdata[31:5] == 27'h0 && apb_out.prdata[2:1] == 2'h0) else $error("wake rsvd set");
  a_flag_reserved_zero: assert property (rd_acc && apb_in.paddr == 16'h1920 |->
    apb_out.prdata[31:16] == 16'h0 && apb_out.prdata[14:6] == 9'h0) else $error("flag rsvd set");
  a_idle_clocks_off: assert property (!clk_en_out.cpu |->
    clk_en_out.rtc && !clk_en_out.periph) else $error("idle clock set wrong");
  a_active_all_on: assert property (clk_en_out.cpu |-> clk_en_out == 4'hF)
    else $error("active clocks not all on");
  a_wake_restores: assert property (wake_out |=> clk_en_out == 4'hF)
    else $error("wake did not restore clocks");
  a_reset_defaults: assert property (disable iff (1'b0) rst_in |=> ram_ctrl_out == 4'hF
    && clk_en_out == 4'hF && !irq_out) else $error("reset values wrong");
endmodule
bind spc_top spc_checker spc_checker_inst (.ref_clk_in, .rst_in, .apb_in, .apb_out,
  .wake_pin_out, .wake_pin_oe_n_out, .ram_ctrl_out, .single_ram_retention_out,
  .dual_ram_retention_out, .clk_en_out, .wake_out, .irq_out);

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import spc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  spc_apb_req_s req = '0;
  spc_apb_rsp_s rsp;
  spc_rtc_evt_s evt = '0;
  spc_clk_en_s clk_en;
  logic int0_n = 1'b1, int1_n = 1'b1, pirq = 1'b0, idle = 1'b0, bdrv = 1'b1, blvl = 1'b0;
  logic pin, pdat, oe_n, ret_s, ret_d, irq, wake, err, seen, clkout;
  logic [31:0] r, w, x;
  int failures = 0, check_count = 0, cyc = 0, seed = 32'h0CA4;
  always #25 clk = ~clk;
  spc_top spc_top_inst (.ref_clk_in(clk), .rst_in(rst), .apb_in(req), .apb_out(rsp),
    .rtc_evt_in(evt), .wake_pin_in(pin), .wake_pin_out(pdat), .wake_pin_oe_n_out(oe_n),
    .external_interrupt_zero_n_in(int0_n), .external_interrupt_one_n_in(int1_n),
    .periph_irq_in(pirq), .idle_exec_in(idle), .rtc_clock_output_enable_out(clkout),
    .ram_ctrl_out(), .single_ram_retention_out(ret_s), .dual_ram_retention_out(ret_d),
    .clk_en_out(clk_en), .wake_out(wake), .irq_out(irq));
  spc_board_model spc_board_model_inst (.data_in(pdat), .oe_n_in(oe_n),
    .board_en_in(bdrv), .board_lvl_in(blvl), .level_out(pin));
  // comparison and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // apb master: setup, then access held until pready
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    x = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(x, e);
  endtask
  task automatic pulse(input spc_rtc_evt_s e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask
  // expected values
  function automatic logic [31:0] flag_of(input int i);
    return (i == 6) ? 32'h8000 : (32'h1 << i);
  endfunction
  function automatic logic pin_exp(input logic [31:0] c, input logic b);
    return c[3] ? c[4] : b;
  endfunction
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      close_out;
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(16'h1930, 32'h0);
    rd(16'h1920, 32'h0);
    rd(16'h1C28, 32'hF);
    bus(1'b0, 16'h1234, 32'h0);
    chk(err, 32'h1);
    // ram modes; ram contents are never accessed here
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      bus(1'b1, 16'h1C28, r);
      rd(16'h1C28, r & 32'hF);
      chk({ret_s, ret_d}, {30'h0, r[3] & ~r[2], r[1] & ~r[0]});
    end
    // wake pin direction and drive, board lets go of an output line
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      // first four cover every drive and direction pair
      if (i < 4) r[4:3] = 2'(i);
      bus(1'b1, 16'h1930, r);
      bdrv <= ~r[3];
      blvl <= r[5];
      rd(16'h1930, r & 32'h19);
      chk(pin, pin_exp(r, r[5]));
      chk(clkout, r[0]);
    end
    bus(1'b1, 16'h1930, 32'h0);
    bdrv <= 1'b1;
    blvl <= 1'b0;
    // sticky event flags
    r = 32'h0;
    for (int i = 0; i < 7; i++) begin
      pulse(7'(1 << i));
      r = r | flag_of(i);
      rd(16'h1920, r);
    end
    bus(1'b1, 16'h1920, 32'h0);
    rd(16'h1920, r);
    w = $random(seed);
    bus(1'b1, 16'h1920, w);
    rd(16'h1920, r & ~w);
    bus(1'b1, 16'h1920, 32'hFFFF);
    rd(16'h1920, 32'h0);
    // interrupt masked, enabled, cleared
    bus(1'b1, 16'h1944, 32'hF);
    bus(1'b1, 16'h1948, 32'h0);
    pulse(7'h01);
    rd(16'h1940, 32'h1);
    chk(irq, 32'h0);
    bus(1'b1, 16'h1948, 32'hF);
    @(negedge clk);
    chk(irq, 32'h1);
    bus(1'b1, 16'h1944, 32'h1);
    @(negedge clk);
    chk(irq, 32'h0);
    rd(16'h1940, 32'h0);
    // idle entry and wake by each source in turn, pending status cleared first
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 16'h1944, 32'hF);
      bus(1'b1, 16'h194C, (k == 4) ? 32'h1 : 32'h2);
      @(posedge clk);
      idle <= 1'b1;
      @(posedge clk);
      idle <= 1'b0;
      repeat (2) @(negedge clk);
      chk(clk_en, (k == 4) ? 32'h5 : 32'h1);
      rd(16'h194C, (k == 4) ? 32'h11 : 32'h32);
      pirq <= (k < 4);
      repeat (5) @(negedge clk);
      chk(clk_en, (k == 4) ? 32'h5 : 32'h1);
      @(posedge clk);
      case (k)
        0: evt <= 7'h01;
        1: int0_n <= 1'b0;
        2: int1_n <= 1'b0;
        3: blvl <= 1'b1;
        default: pirq <= 1'b1;
      endcase
      seen = 1'b0;
      for (int n = 0; n < 20 && !seen; n++) begin
        @(negedge clk);
        seen = wake;
        @(posedge clk);
        evt <= '0;
      end
      chk(seen, 32'h1);
      @(posedge clk);
      int0_n <= 1'b1;
      int1_n <= 1'b1;
      blvl <= 1'b0;
      pirq <= 1'b0;
      @(negedge clk);
      chk(clk_en, 32'hF);
    end
    // target three keeps the block active on an idle instruction
    bus(1'b1, 16'h194C, 32'h3);
    @(posedge clk);
    idle <= 1'b1;
    @(posedge clk);
    idle <= 1'b0;
    repeat (2) @(negedge clk);
    chk(clk_en, 32'hF);
    rd(16'h194C, 32'h03);
    close_out;
  end
endmodule
